/* File: rtl/lblc_top.v */
/*
  Band lock and inline cipher logic of a self-encrypting drive: band
  table, credentials, lock state, wrapped key store, random source and
  the media data path through the cipher stage and an output FIFO.
  Assumes commands arrive already parsed from the storage interface and
  that the media stream and commands are synchronous to sys_clk.
*/
`timescale 1ns/10ps
`include "lblc_consts.vh"
module lblc_top
#(
  parameter DATA_W   = 32,
  parameter LBA_W    = 32,
  parameter KW       = 256,
  parameter BANDS    = 16,
  parameter BIW      = 4,
  parameter FIFO_D   = 4,
  parameter FIFO_AW  = 2,
  parameter [LBA_W-1:0] LBA_MAX = 32'h0fff_ffff
)
(
  // Clock and reset
  input  wire              sys_clk,
  input  wire              arst_n,
  // Parsed commands from the storage interface
  input  wire              cmdValid,
  output wire              cmdReady,
  input  wire [7:0]        cmdCdb,
  input  wire [4:0]        cmdSvc,
  input  wire [3:0]        cmdCode,
  input  wire [1:0]        cmdWho,
  input  wire [BIW-1:0]    cmdBand,
  input  wire [KW-1:0]     cmdCred,
  input  wire [KW-1:0]     cmdNew,
  input  wire [LBA_W-1:0]  cmdLba,
  input  wire [LBA_W-1:0]  cmdLen,
  input  wire [`LBLC_CFG_W-1:0] cmdCfg,
  // Command answer
  output reg               rspValid_r,
  output reg               rspOk_r,
  output reg  [KW-1:0]     rspData_r,
  // Power loss indication
  input  wire              powerLossEvt,
  // Media stream in
  input  wire              medValid,
  output wire              medReady,
  input  wire              medWrite,
  input  wire [LBA_W-1:0]  medLba,
  input  wire [DATA_W-1:0] medData,
  output reg               medRefused_r,
  // Ciphered stream out
  output wire              outValid,
  input  wire              outReady,
  output wire              outWrite,
  output wire [DATA_W-1:0] outData,
  // Status
  output wire              fwDownloadOpen,
  output wire [BANDS-1:0]  bandRdLocked,
  output wire [BANDS-1:0]  bandWrLocked
);

  localparam [2:0] ST_KEK  = 3'h1;
  localparam [2:0] ST_INIT = 3'h2;
  localparam [2:0] ST_RUN  = 3'h4;

  reg  [1:0]        rstPipe_r;
  wire              rstN;
  reg  [2:0]        state_r;
  reg  [BIW-1:0]    initIdx_r;
  reg  [KW-1:0]     rng_r;
  reg  [KW-1:0]     kek_r;
  reg  [KW-1:0]     ownerCred_r;
  reg  [KW-1:0]     eraseCred_r;
  reg  [KW-1:0]     keyWrap_r   [0:BANDS-1];
  reg  [KW-1:0]     bandCred_r  [0:BANDS-1];
  reg  [LBA_W-1:0]  bandStart_r [0:BANDS-1];
  reg  [LBA_W-1:0]  bandEnd_r   [0:BANDS-1];
  reg  [BANDS-1:0]  bandDef_r;
  reg  [BANDS-1:0]  bandEn_r;
  reg  [BANDS-1:0]  rdLock_r;
  reg  [BANDS-1:0]  wrLock_r;
  reg  [BANDS-1:0]  rdArm_r;
  reg  [BANDS-1:0]  wrArm_r;
  reg  [BANDS-1:0]  trig_r;
  reg               fwOpen_r;
  wire              running;
  wire [BANDS-1:0]  hit;
  wire [BANDS-1:0]  ovl;
  reg  [BIW-1:0]    sel;
  reg  [KW-1:0]     selCred;
  reg               cmdOk;
  reg  [1:0]        rspSel;
  reg  [DATA_W-1:0] keyStream;
  wire [KW-1:0]     liveKey;
  wire              credMatch;
  wire              adminOk;
  wire              lockOk;
  wire              eraseOk;
  wire [LBA_W:0]    rngEnd;
  wire              fits;
  wire              cmdTake;
  wire              isSan;
  wire              locked;
  wire              medTake;
  wire              fifoInReady;
  integer           i;
  integer           j;
  integer           k;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; only the second is used
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rstPipe_r <= 2'b00;
    else
      rstPipe_r <= {rstPipe_r[0], 1'b1};
  end
  assign rstN = rstPipe_r[1];

  assign running        = state_r[2];
  assign cmdReady       = running;
  assign fwDownloadOpen = fwOpen_r;
  assign bandRdLocked   = rdLock_r;
  assign bandWrLocked   = wrLock_r;

  ////////////////////////////////////////////////////////////////////////
  // Credential check; the selected slot is compared, never returned
  always @*
  begin
    case (cmdWho)
      `LBLC_WHO_OWNER:   selCred = ownerCred_r;
      `LBLC_WHO_FACTORY: selCred = `LBLC_FACTORY_CRED;
      `LBLC_WHO_ERASE:   selCred = eraseCred_r;
      default:           selCred = bandCred_r[cmdBand];
    endcase
  end
  assign credMatch = (cmdCred == selCred);
  assign adminOk   = credMatch & ((cmdWho == `LBLC_WHO_OWNER) | (cmdWho == `LBLC_WHO_FACTORY));
  assign lockOk    = credMatch & ((cmdWho == `LBLC_WHO_ERASE) | (cmdWho == `LBLC_WHO_BAND));
  assign eraseOk   = credMatch & (cmdWho == `LBLC_WHO_ERASE);

  // Requested span; one extra bit catches wrap past the top LBA
  assign rngEnd = {1'b0, cmdLba} + {1'b0, cmdLen} - {{LBA_W{1'b0}}, 1'b1};
  assign fits   = (cmdLen != {LBA_W{1'b0}}) & (rngEnd <= {1'b0, LBA_MAX});

  ////////////////////////////////////////////////////////////////////////
  // Per band: overlap with the request, and membership of the media LBA
  genvar g;
  generate
    for (g = 0; g < BANDS; g = g + 1)
    begin : gBand
      // Band 0 is the remainder, so it never blocks or claims a span
      assign ovl[g] = (g != `LBLC_BAND_GLOBAL) & (g != cmdBand) & bandDef_r[g] &
                      ~((rngEnd[LBA_W-1:0] < bandStart_r[g]) | (cmdLba > bandEnd_r[g]));
      assign hit[g] = (g != `LBLC_BAND_GLOBAL) & bandDef_r[g] &
                      (medLba >= bandStart_r[g]) & (medLba <= bandEnd_r[g]);
    end
  endgenerate

  // Spans never overlap, so at most one hit; none falls back to band 0
  always @*
  begin
    sel = {BIW{1'b0}};
    for (j = 0; j < BANDS; j = j + 1)
      sel = sel | ({BIW{hit[j]}} & j[BIW-1:0]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Command acceptance by opcode, authority and band table state
  assign cmdTake = cmdValid & running;
  assign isSan   = (cmdCdb == `LBLC_CDB_SANITIZE) & (cmdSvc == `LBLC_SA_CRYPTO);
  always @*
  begin
    cmdOk  = 1'b0;
    rspSel = `LBLC_RSP_NONE;
    if (isSan)
      cmdOk = 1'b1;
    else if (cmdCdb == `LBLC_CDB_SEC_IN)
    begin
      if (cmdCode == `LBLC_CMD_FACT_RD)
      begin
        cmdOk  = 1'b1;
        rspSel = `LBLC_RSP_FACT;
      end
      else if (cmdCode == `LBLC_CMD_RANDOM)
      begin
        cmdOk  = 1'b1;
        rspSel = `LBLC_RSP_RNG;
      end
    end
    else if (cmdCdb == `LBLC_CDB_SEC_OUT)
    begin
      case (cmdCode)
        `LBLC_CMD_FW_LOCK,
        `LBLC_CMD_SET_OWNER: cmdOk = adminOk;
        `LBLC_CMD_SET_ERASE: cmdOk = eraseOk;
        `LBLC_CMD_ENABLE:    cmdOk = eraseOk & (cmdBand > `LBLC_BAND_FIRST_EN);
        `LBLC_CMD_SET_BCRED,
        `LBLC_CMD_LOCKCFG,
        `LBLC_CMD_REKEY:     cmdOk = lockOk;
        `LBLC_CMD_RANGE:     cmdOk = lockOk & (cmdBand != `LBLC_BAND_GLOBAL) &
                                     bandEn_r[cmdBand] & fits & ~|ovl;
        default:             cmdOk = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Random source, key store, band table and lock state
  // The LFSR runs every cycle so successive draws differ
  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rng_r        <= `LBLC_RNG_SEED;
      kek_r        <= {KW{1'b0}};
      state_r      <= ST_KEK;
      initIdx_r    <= {BIW{1'b0}};
      ownerCred_r  <= `LBLC_FACTORY_CRED;
      eraseCred_r  <= `LBLC_FACTORY_CRED;
      bandDef_r    <= {{(BANDS-1){1'b0}}, 1'b1};
      bandEn_r     <= {{(BANDS-2){1'b0}}, 2'b11};
      rdLock_r     <= {BANDS{1'b0}};
      wrLock_r     <= {BANDS{1'b0}};
      rdArm_r      <= {BANDS{1'b0}};
      wrArm_r      <= {BANDS{1'b0}};
      trig_r       <= {BANDS{1'b0}};
      fwOpen_r     <= `LBLC_FW_OPEN_RST;
      rspValid_r   <= 1'b0;
      rspOk_r      <= 1'b0;
      rspData_r    <= {KW{1'b0}};
      for (i = 0; i < BANDS; i = i + 1)
      begin
        keyWrap_r[i]   <= {KW{1'b0}};
        bandCred_r[i]  <= `LBLC_FACTORY_CRED;
        bandStart_r[i] <= {LBA_W{1'b0}};
        bandEnd_r[i]   <= LBA_MAX;
      end
    end
    else
    begin
      rng_r <= {rng_r[KW-2:0], rng_r[255] ^ rng_r[253] ^ rng_r[250] ^ rng_r[245]};
      rspValid_r <= cmdTake;
      rspOk_r    <= cmdTake & cmdOk;
      // Answer data only ever carries public values
      if (cmdTake)
        rspData_r <= (rspSel == `LBLC_RSP_FACT) ? `LBLC_FACTORY_CRED :
                     (rspSel == `LBLC_RSP_RNG)  ? rng_r : {KW{1'b0}};
      case (state_r)
        ST_KEK:
        begin
          kek_r   <= rng_r;
          state_r <= ST_INIT;
        end
        ST_INIT:
        begin
          // One fresh key per cycle, stored wrapped under the KEK
          keyWrap_r[initIdx_r] <= rng_r ^ kek_r;
          initIdx_r <= initIdx_r + 1'b1;
          if (initIdx_r == BANDS[BIW-1:0] - 1'b1)
            state_r <= ST_RUN;
        end
        ST_RUN:
        begin
          if (cmdTake & cmdOk)
          begin
            if (isSan)
              state_r <= ST_INIT;
            else
            begin
              case (cmdCode)
                `LBLC_CMD_FW_LOCK:   fwOpen_r <= ~cmdCfg[`LBLC_CFG_RLOCK];
                `LBLC_CMD_SET_OWNER: ownerCred_r <= cmdNew;
                `LBLC_CMD_SET_ERASE: eraseCred_r <= cmdNew;
                `LBLC_CMD_SET_BCRED: bandCred_r[cmdBand] <= cmdNew;
                `LBLC_CMD_ENABLE:    bandEn_r[cmdBand] <= 1'b1;
                `LBLC_CMD_REKEY:     keyWrap_r[cmdBand] <= rng_r ^ kek_r;
                `LBLC_CMD_RANGE:
                begin
                  bandStart_r[cmdBand] <= cmdLba;
                  bandEnd_r[cmdBand]   <= rngEnd[LBA_W-1:0];
                  bandDef_r[cmdBand]   <= 1'b1;
                end
                `LBLC_CMD_LOCKCFG:
                begin
                  rdLock_r[cmdBand] <= cmdCfg[`LBLC_CFG_RLOCK];
                  wrLock_r[cmdBand] <= cmdCfg[`LBLC_CFG_WLOCK];
                  rdArm_r[cmdBand]  <= cmdCfg[`LBLC_CFG_RARM];
                  wrArm_r[cmdBand]  <= cmdCfg[`LBLC_CFG_WARM];
                  trig_r[cmdBand]   <= cmdCfg[`LBLC_CFG_TRIG];
                end
                default:             fwOpen_r <= fwOpen_r;
              endcase
            end
          end
        end
        default: state_r <= ST_KEK;
      endcase
      // Power loss comes last so it wins over an unlock in the same cycle
      if (powerLossEvt)
      begin
        for (i = 0; i < BANDS; i = i + 1)
        begin
          if (trig_r[i] & rdArm_r[i] & wrArm_r[i])
          begin
            rdLock_r[i] <= 1'b1;
            wrLock_r[i] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cipher stage: key is unwrapped only here and folded to a keystream.
  // The round function is a compact stand-in for the full cipher core.
  assign liveKey = keyWrap_r[sel] ^ kek_r;
  always @*
  begin
    keyStream = {DATA_W{1'b0}};
    for (k = 0; k < KW; k = k + 1)
      keyStream[k % DATA_W] = keyStream[k % DATA_W] ^ liveKey[k] ^ medLba[k % LBA_W];
  end

  // Locked bands are taken and refused so the source never hangs
  assign locked   = medWrite ? wrLock_r[sel] : rdLock_r[sel];
  assign medReady = running & fifoInReady;
  assign medTake  = medValid & medReady;

  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      medRefused_r <= 1'b0;
    else
      medRefused_r <= medTake & locked;
  end

  // Only path from media input to output; no bypass exists
  lblc_fifo
  #(
    .W     (DATA_W + 1),
    .DEPTH (FIFO_D),
    .AW    (FIFO_AW)
  )
  uFifo
  (
    .clk      (sys_clk),
    .rst_n    (rstN),
    .inValid  (medTake & ~locked),
    .inReady  (fifoInReady),
    .inData   ({medWrite, medData ^ keyStream}),
    .outValid (outValid),
    .outReady (outReady),
    .outData  ({outWrite, outData})
  );

endmodule

/* File: rtl/lblc_consts.vh */
/*
  Constants of the band lock and inline cipher block: command opcodes,
  command codes, credential selectors, lock setting bit positions and
  reset values. Assumes it is included by bare name from rtl/.
*/
`ifndef LBLC_CONSTS_VH
`define LBLC_CONSTS_VH

// Storage-interface operation codes
`define LBLC_CDB_SEC_OUT   8'hb5
`define LBLC_CDB_SEC_IN    8'ha2
`define LBLC_CDB_SANITIZE  8'h48
`define LBLC_SA_CRYPTO     5'h03

// Security command codes carried in the payload
`define LBLC_CMD_FACT_RD   4'h0
`define LBLC_CMD_RANDOM    4'h1
`define LBLC_CMD_FW_LOCK   4'h2
`define LBLC_CMD_SET_OWNER 4'h3
`define LBLC_CMD_SET_ERASE 4'h4
`define LBLC_CMD_SET_BCRED 4'h5
`define LBLC_CMD_ENABLE    4'h6
`define LBLC_CMD_RANGE     4'h7
`define LBLC_CMD_LOCKCFG   4'h8
`define LBLC_CMD_REKEY     4'h9

// Which credential the request presents
`define LBLC_WHO_OWNER     2'h0
`define LBLC_WHO_FACTORY   2'h1
`define LBLC_WHO_ERASE     2'h2
`define LBLC_WHO_BAND      2'h3

// Lock setting bits in cmdCfg
`define LBLC_CFG_RLOCK     0
`define LBLC_CFG_WLOCK     1
`define LBLC_CFG_RARM      2
`define LBLC_CFG_WARM      3
`define LBLC_CFG_TRIG      4
`define LBLC_CFG_W         5

// Response data selectors
`define LBLC_RSP_NONE      2'h0
`define LBLC_RSP_FACT      2'h1
`define LBLC_RSP_RNG       2'h2

// Reset values; the seed and factory credential are arbitrary
`define LBLC_RNG_SEED      256'h6a09e667bb67ae853c6ef372a54ff53a510e527f9b05688c1f83d9ab5be0cd19
`define LBLC_FACTORY_CRED  256'h243f6a8885a308d313198a2e03707344a4093822299f31d0082efa98ec4e6c89
`define LBLC_FW_OPEN_RST   1'b1
`define LBLC_BAND_GLOBAL   0
`define LBLC_BAND_FIRST_EN 1

`endif

/* File: rtl/lblc_fifo.v */
/*
  Small flip-flop FIFO with valid/ready on both sides, width and depth
  as parameters. Assumes one clock and a synchronised active-low reset.
*/
`timescale 1ns/10ps
module lblc_fifo
#(
  parameter W     = 33,
  parameter DEPTH = 4,
  parameter AW    = 2
)
(
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Fill side
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  // Drain side
  output wire         outValid,
  input  wire         outReady,
  output wire [W-1:0] outData
);

  reg [W-1:0]  mem_r [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0]   count_r;
  wire         push;
  wire         pop;

  // Full and empty come straight from the occupancy count
  assign inReady  = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  ////////////////////////////////////////////////////////////////////////
  // Pointers wrap explicitly so DEPTH need not be a power of two
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
      if (pop)
        rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
      if (push & ~pop)
        count_r <= count_r + 1'b1;
      else if (pop & ~push)
        count_r <= count_r - 1'b1;
    end
  end

  // Storage needs no reset; empty flag masks stale words
  always @(posedge clk)
  begin
    if (push)
      mem_r[wrPtr_r] <= inData;
  end

endmodule

/* File: testbench/lblc_chk.sv */
/*
  Port checker for lblc_top: command answers, refusals, lock and
  download state changes, FIFO hold. Assumes default port widths.
*/
`timescale 1ns/10ps
`include "lblc_consts.vh"
module lblc_chk
#(
  parameter KW     = 256,
  parameter DATA_W = 32,
  parameter BANDS  = 16
)
(
  // Clock, reset and commands
  input logic              sys_clk,
  input logic              arst_n,
  input logic              cmdValid,
  input logic              cmdReady,
  input logic [7:0]        cmdCdb,
  input logic [4:0]        cmdSvc,
  input logic [3:0]        cmdCode,
  // Answers and status
  input logic              rspValid_r,
  input logic              rspOk_r,
  input logic [KW-1:0]     rspData_r,
  input logic              fwDownloadOpen,
  input logic [BANDS-1:0]  bandRdLocked,
  input logic [BANDS-1:0]  bandWrLocked,
  // Media path
  input logic              powerLossEvt,
  input logic              medValid,
  input logic              medReady,
  input logic              medWrite,
  input logic              medRefused_r,
  input logic              outValid,
  input logic              outReady,
  input logic [DATA_W-1:0] outData
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // A command is taken only on a ready edge
  wire take = cmdValid && cmdReady;

  // Sanitize keeps commands out while all band keys regenerate; the KEK is kept
  sequence s_held;
    !cmdReady [*8] ##[1:10] cmdReady;
  endsequence

  ////////////////////////////////////////////////////////////////
  a_rsp_after_take: assert property (take |=> rspValid_r)
    else $error("no answer after a taken command");
  a_fact_read: assert property (take && cmdCdb == `LBLC_CDB_SEC_IN && cmdCode == `LBLC_CMD_FACT_RD
    |=> rspOk_r && rspData_r == `LBLC_FACTORY_CRED) else $error("factory credential read wrong");
  a_bad_opcode: assert property (take && !(cmdCdb inside {8'hb5, 8'ha2, 8'h48})
    |=> rspValid_r && !rspOk_r) else $error("unknown opcode accepted");
  a_sanitize_block: assert property (take && cmdCdb == 8'h48 && cmdSvc == 5'h03 |=> s_held)
    else $error("sanitize did not hold commands off");
  a_refused_cause: assert property (medRefused_r
    |-> $past(medValid && medReady && (medWrite ? |bandWrLocked : |bandRdLocked)))
    else $error("beat refused without a lock");
  a_lock_cause: assert property (!$stable({bandRdLocked, bandWrLocked}) |-> $past(take || powerLossEvt))
    else $error("lock state changed on its own");
  a_fifo_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("output beat lost while stalled");
  a_fw_cause: assert property (!$stable(fwDownloadOpen)
    |-> $past(take && cmdCdb == 8'hb5 && cmdCode == `LBLC_CMD_FW_LOCK))
    else $error("download lock changed without a command");
endmodule

bind lblc_top lblc_chk #(.KW(KW), .DATA_W(DATA_W), .BANDS(BANDS)) u_chk (.sys_clk, .arst_n, .cmdValid,
  .cmdReady, .cmdCdb, .cmdSvc, .cmdCode, .rspValid_r, .rspOk_r, .rspData_r, .fwDownloadOpen, .bandRdLocked,
  .bandWrLocked, .powerLossEvt, .medValid, .medReady, .medWrite, .medRefused_r, .outValid, .outReady, .outData);

/* File: testbench/lblc_host_model.sv */
/*
  Host initiator model: issues one parsed security command at a time.
  Assumes commands are taken on a ready edge and answered one cycle on.
*/
`timescale 1ns/10ps
module lblc_host_model
(
  // Clock
  input  logic         sys_clk,
  // Command request
  output logic         cmdValid,
  input  logic         cmdReady,
  output logic [7:0]   cmdCdb,
  output logic [4:0]   cmdSvc,
  output logic [3:0]   cmdCode,
  output logic [1:0]   cmdWho,
  output logic [3:0]   cmdBand,
  output logic [255:0] cmdCred,
  output logic [255:0] cmdNew,
  output logic [31:0]  cmdLba,
  output logic [31:0]  cmdLen,
  output logic [4:0]   cmdCfg,
  // Answer
  input  logic         rspOk_r,
  input  logic [255:0] rspData_r
);
  // Idle bus; service action fixed at the erase value
  initial
  begin
    {cmdValid, cmdCdb, cmdCode, cmdWho, cmdBand, cmdCred, cmdNew, cmdLba, cmdLen, cmdCfg} = '0;
    cmdSvc = 5'h03;
  end

  // Request held until the taking edge, then the credential is scrambled
  task issue(input [7:0] cdb, input [3:0] code, input [1:0] who, input [3:0] band, input [255:0] cred,
             input [31:0] lba, input [31:0] len, input [4:0] cfg, output ok, output [255:0] data);
    @(posedge sys_clk) #1;
    {cmdValid, cmdCdb, cmdCode, cmdWho, cmdBand, cmdCred, cmdNew} = {1'b1, cdb, code, who, band, cred, cred};
    {cmdLba, cmdLen, cmdCfg} = {lba, len, cfg};
    while (!cmdReady) @(posedge sys_clk) #1;
    @(posedge sys_clk) #1;
    cmdValid = 0;
    cmdCred = ~cmdCred;
    ok = rspOk_r;
    data = rspData_r;
  endtask
endmodule

/* File: testbench/lblc_top_tb_top.sv */
/*
  Testbench of lblc_top: host model on the command side, the bench
  drives media beats and drains the output FIFO. Assumes 20 MHz clock.
*/
`timescale 1ns/10ps
`include "lblc_consts.vh"
module lblc_top_tb_top;
  localparam [255:0] FAC = `LBLC_FACTORY_CRED;
  localparam [31:0]  D   = 32'hc0ffee11;
  logic sys_clk, arst_n, powerLossEvt, medValid, medWrite, outReady, ok, rf;
  logic [31:0] medLba, medData, a, b, c;
  logic [255:0] rd;
  wire cmdValid, cmdReady, rspValid_r, rspOk_r, medReady, medRefused_r, outValid, outWrite, fwDownloadOpen;
  wire [7:0] cmdCdb;
  wire [4:0] cmdSvc, cmdCfg;
  wire [3:0] cmdCode, cmdBand;
  wire [1:0] cmdWho;
  wire [255:0] cmdCred, cmdNew, rspData_r;
  wire [31:0] cmdLba, cmdLen, outData;
  wire [15:0] bandRdLocked, bandWrLocked;
  int failures, totalChecks;

  lblc_top DUT (.sys_clk, .arst_n, .cmdValid, .cmdReady, .cmdCdb, .cmdSvc, .cmdCode, .cmdWho, .cmdBand,
    .cmdCred, .cmdNew, .cmdLba, .cmdLen, .cmdCfg, .rspValid_r, .rspOk_r, .rspData_r, .powerLossEvt,
    .medValid, .medReady, .medWrite, .medLba, .medData, .medRefused_r, .outValid, .outReady, .outWrite,
    .outData, .fwDownloadOpen, .bandRdLocked, .bandWrLocked);
  lblc_host_model host (.sys_clk, .cmdValid, .cmdReady, .cmdCdb, .cmdSvc, .cmdCode, .cmdWho, .cmdBand,
    .cmdCred, .cmdNew, .cmdLba, .cmdLen, .cmdCfg, .rspOk_r, .rspData_r);

  // 50 ns clock
  initial
  begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////
  task chk(input [255:0] got, input [255:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cmd(input [7:0] cdb, input [3:0] code, input [1:0] who, input [3:0] band, input [255:0] cred,
           input [31:0] lba, input [31:0] len, input [4:0] cfg);
    host.issue(cdb, code, who, band, cred, lba, len, cfg, ok, rd);
  endtask

  // One media beat, held until taken; rf tells whether it was dropped
  task med(input w, input [31:0] l, input [31:0] dt);
    @(posedge sys_clk) #1;
    {medValid, medWrite, medLba, medData} = {1'b1, w, l, dt};
    while (!medReady) @(posedge sys_clk) #1;
    @(posedge sys_clk) #1;
    medValid = 0;
    medData = ~medData;
    rf = medRefused_r;
  endtask

  // Output side stalls until asked, then pops one beat
  task pop(output [31:0] o);
    while (!outValid) @(posedge sys_clk) #1;
    o = outData;
    outReady = 1;
    @(posedge sys_clk) #1;
    outReady = 0;
  endtask

  task xfer(input w, input [31:0] l, input [31:0] dt, output [31:0] o);
    med(w, l, dt);
    pop(o);
  endtask

  ////////////////////////////////////////////////////////////////
  task t_factory;
    cmd(8'ha2, 4'h0, 2'h0, 4'h0, 256'h0, 32'h0, 32'h0, 5'h00);
    chk(rd, FAC);
    chk(fwDownloadOpen, 1);
    chk(bandRdLocked | bandWrLocked, 0);
    cmd(8'ha2, 4'h1, 2'h0, 4'h0, 256'h0, 32'h0, 32'h0, 5'h00);
    a = rd[31:0];
    cmd(8'ha2, 4'h1, 2'h0, 4'h0, 256'h0, 32'h0, 32'h0, 5'h00);
    chk(a !== rd[31:0], 1);
    cmd(8'h28, 4'h0, 2'h0, 4'h0, FAC, 32'h0, 32'h0, 5'h00);
    chk(ok, 0);
    $display("t_factory done");
  endtask

  task t_auth;
    cmd(8'hb5, 4'h2, 2'h1, 4'h0, ~FAC, 32'h0, 32'h0, 5'h01);
    chk({ok, fwDownloadOpen}, 2'b01);
    cmd(8'hb5, 4'h2, 2'h2, 4'h0, FAC, 32'h0, 32'h0, 5'h01);
    chk(ok, 0);
    cmd(8'hb5, 4'h2, 2'h0, 4'h0, FAC, 32'h0, 32'h0, 5'h01);
    chk({ok, fwDownloadOpen}, 2'b10);
    cmd(8'hb5, 4'h2, 2'h1, 4'h0, FAC, 32'h0, 32'h0, 5'h00);
    chk({ok, fwDownloadOpen}, 2'b11);
    cmd(8'hb5, 4'h6, 2'h0, 4'h2, FAC, 32'h0, 32'h0, 5'h00);
    chk(ok, 0);
    $display("t_auth done");
  endtask

  task t_bands;
    cmd(8'hb5, 4'h7, 2'h2, 4'h0, FAC, 32'h0, 32'h10, 5'h00);
    chk(ok, 0);
    cmd(8'hb5, 4'h7, 2'h3, 4'h1, FAC, 32'h1000, 32'h1000, 5'h00);
    chk(ok, 1);
    cmd(8'hb5, 4'h7, 2'h2, 4'h2, FAC, 32'h2000, 32'h1000, 5'h00);
    chk(ok, 0);
    cmd(8'hb5, 4'h6, 2'h2, 4'h2, FAC, 32'h0, 32'h0, 5'h00);
    chk(ok, 1);
    cmd(8'hb5, 4'h7, 2'h2, 4'h2, FAC, 32'h1800, 32'h1000, 5'h00);
    chk(ok, 0);
    cmd(8'hb5, 4'h7, 2'h2, 4'h2, FAC, 32'h2000, 32'h1000, 5'h00);
    chk(ok, 1);
    $display("t_bands done");
  endtask

  task t_media;
    xfer(1, 32'h1070, D, a);
    xfer(0, 32'h1070, a, b);
    chk({a !== D, b}, {1'b1, D});
    cmd(8'hb5, 4'h9, 2'h2, 4'h1, FAC, 32'h0, 32'h0, 5'h00);
    xfer(0, 32'h1070, a, c);
    chk({ok, c !== D}, 2'b11);
    xfer(1, 32'h1070, D, b);
    cmd(8'h48, 4'h0, 2'h0, 4'h0, 256'h0, 32'h0, 32'h0, 5'h00);
    chk({ok, cmdReady}, 2'b10);
    xfer(1, 32'h1070, D, c);
    chk(c !== b, 1);
    $display("t_media done");
  endtask

  task t_power;
    cmd(8'hb5, 4'h8, 2'h3, 4'h1, FAC, 32'h0, 32'h0, 5'h1c);
    cmd(8'hb5, 4'h8, 2'h3, 4'h2, FAC, 32'h0, 32'h0, 5'h14);
    chk({ok, bandRdLocked}, 17'h10000);
    powerLossEvt = 1;
    @(posedge sys_clk) #1;
    powerLossEvt = 0;
    chk({bandRdLocked, bandWrLocked}, 32'h00020002);
    med(1, 32'h1070, D);
    chk({rf, outValid}, 2'b10);
    xfer(0, 32'h10, D, a);
    chk(rf, 0);
    cmd(8'hb5, 4'h8, 2'h3, 4'h1, ~FAC, 32'h0, 32'h0, 5'h00);
    chk({ok, bandRdLocked[1]}, 2'b01);
    cmd(8'hb5, 4'h8, 2'h2, 4'h1, FAC, 32'h0, 32'h0, 5'h00);
    chk({ok, bandRdLocked, bandWrLocked}, 33'h100000000);
    $display("t_power done");
  endtask

  task t_fifo;
    for (int i = 0; i < 4; i++) med(1, 32'h10, D + i);
    chk(medReady, 0);
    chk(outWrite, 1);
    pop(a);
    for (int i = 1; i < 4; i++)
    begin
      pop(b);
      chk(a ^ b, D ^ (D + i));
    end
    chk(outValid, 0);
    $display("t_fifo done");
  endtask

  task test_done;
    $display("Checks %0d, mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn
  initial
  begin
    {arst_n, powerLossEvt, medValid, medWrite, medLba, medData, outReady} = '0;
    repeat (4) @(posedge sys_clk);
    #1 arst_n = 1;
    t_factory;
    t_auth;
    t_bands;
    t_media;
    t_power;
    t_fifo;
    test_done;
  end

  // Watchdog far beyond the hundred or so cycles the tests need
  initial
  begin
    #2000000;
    failures++;
    test_done;
  end
endmodule
